// ==== sld_driver.sv ====
// Purpose: 8-channel serial-in, parallel-out LED sink driver core
// Assumes: Pins are sampled by clk_i through two flip-flops; shift clock far below clk_i
// Notes: sink_on_o bit high means the channel sinks current
// What this block does
// - Each rising edge of the shift clock samples serial_in and moves every shift stage one place on.
// - While the latch control is high the latch follows the shift register, while low it holds.
// - With the enable low each output follows its latched bit, with it high all eight are off.
// - The shift register is eight deep, the newest bit drives output 0 and the oldest output 7.
// - The serial output shows the last shift stage, so a chained part sees the data eight clocks later.
// - Reset at power-up forces every sink output off until data and enable are applied.
// - Outputs turn on one after another, about 30 ns apart, after the enable goes active; bits latched while enabled turn on together.
// - The enable gates all eight outputs as one common control, turning them all off together.
`timescale 1ns/1ps
module sld_driver (
  // Clock, reset, freeze
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Controller pins
  input wire sld_pkg::sld_pins_type pins_i,
  // Sink outputs and cascade
  output logic [7:0] sink_on_o,
  output logic serial_out_o
);

  sld_pkg::sld_pins_type sync1_r;
  sld_pkg::sld_pins_type sync2_r;
  logic clk_prev_r;
  logic [7:0] shift_r;
  logic [7:0] latch_r;
  logic [7:0] sink_r;
  logic [7:0] sink_nxt;
  logic [sld_pkg::CNT_W-1:0] on_cnt_r;
  logic shift_edge;
  logic pass_s;
  logic en_s;

  // Two-stage synchroniser for every pin
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= sld_pkg::PINS_RST;
      sync2_r <= sld_pkg::PINS_RST;
      // Same level as the synchronised clock, so no false edge after reset
      clk_prev_r <= sld_pkg::PINS_RST[2];
    end else if (ce_i) begin
      sync1_r <= pins_i;
      sync2_r <= sync1_r;
      clk_prev_r <= sync2_r.shift_clk;
    end
  end

  assign shift_edge = sync2_r.shift_clk & ~clk_prev_r;
  assign pass_s = sync2_r.latch_pass_n;
  assign en_s = ~sync2_r.out_en_n;

  // Shift register, newest bit in stage 0
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_r <= sld_pkg::SHIFT_RST;
    end else if (ce_i && shift_edge) begin
      shift_r <= {shift_r[6:0], sync2_r.serial_in};
    end
  end

  assign serial_out_o = shift_r[7];

  // Level-sensitive latch, high passes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_r <= sld_pkg::LATCH_RST;
    end else if (ce_i && pass_s) begin
      latch_r <= shift_r;
    end
  end

  // Cycles since the enable went active, saturating
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      on_cnt_r <= sld_pkg::CNT_RST;
    end else if (ce_i) begin
      if (!en_s) begin
        on_cnt_r <= sld_pkg::CNT_RST;
      end else if (on_cnt_r != sld_pkg::CNT_SAT) begin
        on_cnt_r <= on_cnt_r + 5'h01;
      end
    end
  end

  // Channel k released k stagger steps after enable; off is immediate for all
  always_comb begin
    sink_nxt = 8'h00;
    for (int k = 0; k < sld_pkg::NUM_CH; k++) begin
      if (en_s && (int'(on_cnt_r) >= k * sld_pkg::STAGGER_CYC)) begin
        sink_nxt[k] = latch_r[k];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sink_r <= sld_pkg::SINK_RST;
    end else if (ce_i) begin
      sink_r <= sink_nxt;
    end
  end

  assign sink_on_o = sink_r;

  // Checks
  sequence s_shift_taken;
    ce_i && shift_edge;
  endsequence

  a_shift_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    s_shift_taken |=> shift_r[7:1] == $past(shift_r[6:0]))
    else $error("shift register did not advance");

  a_newest_first: assert property (@(posedge clk_i) disable iff (rst_i)
    s_shift_taken |=> shift_r[0] == $past(sync2_r.serial_in))
    else $error("newest bit not in stage 0");

  a_serial_tail: assert property (@(posedge clk_i) disable iff (rst_i)
    s_shift_taken |=> serial_out_o == $past(shift_r[6]))
    else $error("serial output not last stage");

  a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !pass_s) |=> latch_r == $past(latch_r))
    else $error("latch changed while holding");

  a_latch_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && pass_s && !shift_edge) ##1 (ce_i && pass_s) |=> latch_r == $past(shift_r, 2))
    else $error("latch not transparent");

  a_outputs_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && en_s && on_cnt_r == sld_pkg::CNT_SAT) |=> sink_on_o == $past(latch_r))
    else $error("outputs do not follow latch");

  a_common_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !en_s) |=> sink_on_o == 8'h00)
    else $error("outputs not all off with enable high");

  a_por_off: assert property (@(posedge clk_i)
    rst_i |-> sink_on_o == 8'h00 && latch_r == 8'h00)
    else $error("outputs on during reset");

  a_stagger_first: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && en_s && on_cnt_r == 5'h00) |=> sink_on_o[7:1] == 7'h00)
    else $error("later channels turned on too early");

  a_stagger_ch1: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && en_s && on_cnt_r == sld_pkg::CNT_W'(sld_pkg::STAGGER_CYC) && latch_r[1]) |=> sink_on_o[1])
    else $error("channel 1 not released after one step");

  // Edge path, stability, latch pass and freeze
  sequence s_clk_rise;
    (ce_i && !sync2_r.shift_clk) ##1 (ce_i && sync2_r.shift_clk);
  endsequence

  a_rise_shifts: assert property (@(posedge clk_i) disable iff (rst_i)
    s_clk_rise |=> shift_r[0] == $past(sync2_r.serial_in))
    else $error("synchronised clock rise did not shift");

  a_shift_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !shift_edge) |=> shift_r == $past(shift_r))
    else $error("shift register moved without a clock edge");

  a_serial_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !shift_edge) |=> serial_out_o == $past(serial_out_o))
    else $error("serial output moved without a clock edge");

  a_latch_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && pass_s) |=> latch_r == $past(shift_r))
    else $error("latch did not pass the shift register");

  a_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> shift_r == $past(shift_r) && latch_r == $past(latch_r)
      && sink_r == $past(sink_r) && on_cnt_r == $past(on_cnt_r)
      && sync2_r == $past(sync2_r))
    else $error("state moved while frozen");

  // Enable counter, turn-on stagger, latch gating and shift reset
  a_cnt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !en_s) |=> on_cnt_r == sld_pkg::CNT_RST)
    else $error("stagger counter not cleared with enable off");

  a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && en_s && on_cnt_r != sld_pkg::CNT_SAT) |=> on_cnt_r == $past(on_cnt_r) + 5'h01)
    else $error("stagger counter did not step");

  a_cnt_sat: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && en_s && on_cnt_r == sld_pkg::CNT_SAT) |=> on_cnt_r == sld_pkg::CNT_SAT)
    else $error("stagger counter left saturation");

  a_stagger_ch7: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && en_s && on_cnt_r != sld_pkg::CNT_SAT) |=> !sink_on_o[7])
    else $error("last channel turned on too early");

  a_latch_gates: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> (sink_on_o & ~$past(latch_r)) == 8'h00)
    else $error("output on without its latched bit");

  sequence s_enable_start;
    (ce_i && !en_s) ##1 (ce_i && en_s);
  endsequence

  a_enable_start: assert property (@(posedge clk_i) disable iff (rst_i)
    s_enable_start |=> sink_on_o[0] == $past(latch_r[0]) && sink_on_o[7:1] == 7'h00)
    else $error("first channel not released alone at enable");

  a_stagger_early: assert property (@(posedge clk_i) disable iff (rst_i)
    s_enable_start ##1 (ce_i && en_s) [*2] |=> !sink_on_o[1])
    else $error("channel 1 released before one stagger step");

  a_stagger_walk: assert property (@(posedge clk_i) disable iff (rst_i)
    s_enable_start ##1 (ce_i && en_s) [*3] |=> sink_on_o[1] == $past(latch_r[1]) && !sink_on_o[2])
    else $error("stagger step order broken");

  a_por_shift: assert property (@(posedge clk_i)
    rst_i |-> shift_r == sld_pkg::SHIFT_RST && serial_out_o == 1'b0)
    else $error("shift register not cleared during reset");

endmodule

// ==== sld_pkg.sv ====
// Purpose: Shared constants and pin bundle for the serial-in LED sink driver
// Assumes: System clock of 100 MHz; all pins arrive asynchronous to it
// Notes: Times are kept in ns, cycle counts are derived from them
package sld_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int NUM_CH = 8;

  // Turn-on stagger between neighbouring channels, least time, rounded up
  localparam int STAGGER_NS = 30;
  localparam int STAGGER_CYC = (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Count at which every channel has been released
  localparam int STAGGER_SAT = (NUM_CH - 1) * STAGGER_CYC;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_SAT = CNT_W'(STAGGER_SAT);

  // Shortest enable pulse and fastest shift clock the controller may apply
  localparam int MIN_EN_PULSE_NS = 180;
  localparam int MAX_SHIFT_MHZ = 25;

  // Reset values
  localparam logic [NUM_CH-1:0] SHIFT_RST = 8'h00;
  localparam logic [NUM_CH-1:0] LATCH_RST = 8'h00;
  localparam logic [NUM_CH-1:0] SINK_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [3:0] PINS_RST = 4'h5;

  // Pin bundle from the display controller
  typedef struct packed {
    logic serial_in;
    logic shift_clk;
    logic latch_pass_n;
    logic out_en_n;
  } sld_pins_type;

endpackage

// ==== sld_ctrl_model.sv ====
// Purpose: Display controller model driving the sink driver pins
// Assumes: clk_i at 100 MHz; pins change 1 ns after a rising edge
// Notes: Shift clock spends four cycles in each phase
`timescale 1ns/1ps
module sld_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Pins to the driver
  output sld_pkg::sld_pins_type pins_o
);
  initial pins_o = sld_pkg::PINS_RST;
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Oldest bit first, so it ends on output 7
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      pins_o.shift_clk = 1'b0;
      pins_o.serial_in = b[i];
      step(4);
      pins_o.shift_clk = 1'b1;
      step(4);
    end
  endtask
  task automatic latch_pulse();
    pins_o.latch_pass_n = 1'b1;
    step(6);
    pins_o.latch_pass_n = 1'b0;
    step(6);
  endtask
  task automatic set_enable(input logic on);
    pins_o.out_en_n = ~on;
    step(32);
  endtask
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for the sink driver
// Assumes: Controller model makes every pin change
// Notes: Result is serial_out_o over sink_on_o
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  sld_pkg::sld_pins_type pins;
  logic [7:0] sink_on_o;
  logic serial_out_o;
  logic [8:0] exp_q[$];
  int errors = 0;
  int check_count = 0;
  int seed = 32'h084f;
  logic [7:0] b;
  logic [7:0] prev;
  event look;
  initial forever #5 clk_i = ~clk_i;
  sld_ctrl_model ctrl (.clk_i(clk_i), .pins_o(pins));
  sld_driver DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pins_i(pins),
    .sink_on_o(sink_on_o), .serial_out_o(serial_out_o));
  task automatic test_done();
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic compare(input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic note(input logic [8:0] exp);
    exp_q.push_back(exp);
    ->look;
  endtask
  always @(look) begin
    compare(exp_q.pop_front(), {serial_out_o, sink_on_o});
  end
  initial begin
    repeat (6) @(posedge clk_i);
    #1 rst_i = 1'b0;
    ctrl.step(4);
    note(9'h000);
    prev = 8'h00;
    for (int k = 0; k < 6; k++) begin
      b = 8'($random(seed));
      ctrl.send_byte(b);
      if (k % 2 == 0) begin
        ctrl.latch_pulse();
        prev = b;
      end
      ctrl.set_enable(1'b1);
      note({b[7], prev});
      ctrl.set_enable(1'b0);
      note({b[7], 8'h00});
    end
    ctrl.set_enable(1'b1);
    note({b[7], prev});
    ce_i = 1'b0;
    ctrl.set_enable(1'b0);
    note({b[7], prev});
    ce_i = 1'b1;
    ctrl.step(4);
    note({b[7], 8'h00});
    ctrl.set_enable(1'b1);
    rst_i = 1'b1;
    ctrl.step(2);
    note(9'h000);
    rst_i = 1'b0;
    ctrl.step(4);
    note(9'h000);
    test_done();
  end
  initial begin
    #50000;
    errors++;
    test_done();
  end
endmodule
